// ==== design/dwmem_cfg.svh ====
// dwmem_cfg.svh: constants of the sixteen word dataway memory
// assumes inclusion by bare name from the package and design files
`ifndef DWMEM_CFG_SVH
`define DWMEM_CFG_SVH

`define DWMEM_WORD_W 24
`define DWMEM_DEPTH 16
`define DWMEM_ADDR_W 4
`define DWMEM_FUNC_W 5
`define DWMEM_FIFO_DEPTH 32
`define DWMEM_ADDR_RST 4'h0

`define DWMEM_F_READ_RAND 5'h00
`define DWMEM_F_READ_ADDR 5'h01
`define DWMEM_F_READ_SEQ 5'h04
`define DWMEM_F_WRITE_RAND 5'h10
`define DWMEM_F_LOAD_ADDR 5'h11
`define DWMEM_F_WRITE_SEQ 5'h14
`define DWMEM_SUB_ZERO 4'h0

`endif

// ==== design/dwmem_pkg.sv ====
// dwmem_pkg: shared types of the dataway memory and its controller
// assumes dwmem_cfg.svh is on the include path
`include "dwmem_cfg.svh"

package dwmem_pkg;
    typedef logic [`DWMEM_WORD_W-1:0] dwmem_word_t;
    typedef logic [`DWMEM_ADDR_W-1:0] dwmem_addr_t;
    typedef logic [`DWMEM_FUNC_W-1:0] dwmem_func_t;

    typedef enum logic [1:0] {
        DWMEM_IDLE = 2'b00,
        DWMEM_CYCLE = 2'b01,
        DWMEM_ANSWER = 2'b10
    } dwmem_state_e;
endpackage

// ==== design/dwmem_if.sv ====
// dwmem_if: dataway signals between crate controller and memory module
// assumes one clock shared by both ends; read lines qualified by r_oe
`timescale 1ns/1ps
`default_nettype none

interface dwmem_if;
    import dwmem_pkg::*;
    logic cyc;
    logic n;
    dwmem_addr_t a;
    dwmem_func_t f;
    dwmem_word_t w;
    logic z;
    logic c;
    dwmem_word_t r;
    logic r_oe;
    logic q;
    logic x;
    logic ack;
    logic lam;

    modport dev (input cyc, n, a, f, w, z, c, output r, r_oe, q, x, ack, lam);
    modport ctl (output cyc, n, a, f, w, z, c, input r, r_oe, q, x, ack, lam);
endinterface

`default_nettype wire

// ==== design/dwmem_device.sv ====
// dwmem_device: sixteen word 24-bit memory module on the dataway,
// with a rear strobe port buffered through a fifo.
// assumes commands arrive as one-cycle cyc pulses, z and c as levels.
//
// Functional notes
// - sixteen words of 24 bits each
// - z or c clears address register
// - f16 writes word at subaddress
// - f20 a0 writes at address, increments
// - rear strobe writes at address, increments
// - f0 random read, f4 sequential read
// - sequential read increments address register
// - f17 a0 loads, f1 reads address
// - q for every subaddress, never lam
// - panel clear zeroes address; display current word
`timescale 1ns/1ps
`default_nettype none
`include "dwmem_cfg.svh"

module dwmem_fifo #(
    parameter int W = 24,
    parameter int D = 32
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    // depth a power of two, so the pointers wrap by themselves
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic not_full;
    } dwmem_fifo_s;

    dwmem_fifo_s s;
    dwmem_fifo_s next_s;
    logic push;
    logic pop;

    assign in_ready = s.not_full;
    assign out_valid = (s.cnt != '0);
    assign out_data = s.mem[s.rp];

    always_comb begin
        next_s = s;
        push = in_valid && s.not_full;
        pop = out_valid && out_ready;
        if (push) begin
            next_s.mem[s.wp] = in_data;
            next_s.wp = s.wp + 1'b1;
        end
        if (pop) begin
            next_s.rp = s.rp + 1'b1;
        end
        if (push && !pop) begin
            next_s.cnt = s.cnt + 1'b1;
        end else if (pop && !push) begin
            next_s.cnt = s.cnt - 1'b1;
        end
        // registered so the source sees a clean ready
        next_s.not_full = (next_s.cnt != (AW+1)'(D));
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
            s.not_full <= 1'b1;
        end else begin
            s <= next_s;
        end
    end
endmodule

module dwmem_device (
    input wire logic clock,
    input wire logic rstn,
    dwmem_if.dev dw,
    input wire logic rear_strobe,
    input wire dwmem_pkg::dwmem_word_t rear_data,
    output logic rear_ready,
    input wire logic panel_clear,
    output dwmem_pkg::dwmem_word_t display,
    output dwmem_pkg::dwmem_addr_t display_addr
);
    import dwmem_pkg::*;

    typedef struct packed {
        logic [`DWMEM_DEPTH-1:0][`DWMEM_WORD_W-1:0] mem;
        dwmem_addr_t addr;
        dwmem_word_t r;
        logic r_oe;
        logic q;
        logic x;
        logic ack;
        logic lam;
        dwmem_word_t display;
        dwmem_addr_t display_addr;
    } dwmem_dev_s;

    dwmem_dev_s s;
    dwmem_dev_s next_s;
    logic sel;
    logic sub0;
    logic clear;
    logic drain_valid;
    logic drain_ready;
    dwmem_word_t drain_data;

    dwmem_fifo #(
        .W(`DWMEM_WORD_W),
        .D(`DWMEM_FIFO_DEPTH)
    ) rear_fifo (
        .clock(clock),
        .rstn(rstn),
        .in_valid(rear_strobe),
        .in_ready(rear_ready),
        .in_data(rear_data),
        .out_valid(drain_valid),
        .out_ready(drain_ready),
        .out_data(drain_data)
    );

    assign dw.r = s.r;
    assign dw.r_oe = s.r_oe;
    assign dw.q = s.q;
    assign dw.x = s.x;
    assign dw.ack = s.ack;
    assign dw.lam = s.lam;
    assign display = s.display;
    assign display_addr = s.display_addr;

    always_comb begin
        next_s = s;
        sel = dw.cyc && dw.n;
        sub0 = (dw.a == `DWMEM_SUB_ZERO);
        clear = dw.z || dw.c || panel_clear;
        // rear words wait in the fifo while the dataway or a clear owns the address
        drain_ready = !sel && !clear;
        // released read lines show zero rather than the last word
        next_s.r = '0;
        next_s.r_oe = 1'b0;
        next_s.q = 1'b0;
        next_s.x = 1'b0;
        next_s.ack = sel;
        next_s.lam = 1'b0;
        if (sel) begin
            next_s.q = 1'b1;
            if (dw.f == `DWMEM_F_READ_RAND) begin
                next_s.r = s.mem[dw.a];
                next_s.r_oe = 1'b1;
                next_s.x = 1'b1;
            end else if (dw.f == `DWMEM_F_WRITE_RAND) begin
                next_s.mem[dw.a] = dw.w;
                next_s.x = 1'b1;
            // sequential and address functions need subaddress zero
            end else if (dw.f == `DWMEM_F_READ_SEQ && sub0) begin
                next_s.r = s.mem[s.addr];
                next_s.r_oe = 1'b1;
                next_s.addr = s.addr + 1'b1;
                next_s.x = 1'b1;
            end else if (dw.f == `DWMEM_F_WRITE_SEQ && sub0) begin
                next_s.mem[s.addr] = dw.w;
                next_s.addr = s.addr + 1'b1;
                next_s.x = 1'b1;
            end else if (dw.f == `DWMEM_F_LOAD_ADDR && sub0) begin
                // only the low write bits fit the register
                next_s.addr = dw.w[`DWMEM_ADDR_W-1:0];
                next_s.x = 1'b1;
            end else if (dw.f == `DWMEM_F_READ_ADDR && sub0) begin
                next_s.r = {{(`DWMEM_WORD_W-`DWMEM_ADDR_W){1'b0}}, s.addr};
                next_s.r_oe = 1'b1;
                next_s.x = 1'b1;
            end
        // a strobe while rear_ready is low is lost
        end else if (drain_valid && drain_ready) begin
            next_s.mem[s.addr] = drain_data;
            next_s.addr = s.addr + 1'b1;
        end
        if (clear) begin
            // clears win over any increment in the same cycle
            next_s.addr = `DWMEM_ADDR_RST;
        end
        next_s.display = next_s.mem[next_s.addr];
        next_s.display_addr = next_s.addr;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            // memory is flops, so a reset clears every word
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

`default_nettype wire

// ==== design/dwmem_ctrl.sv ====
// dwmem_ctrl: crate controller end, runs one dataway cycle per request
// assumes the user holds req fields while req_valid and req_ready differ
`timescale 1ns/1ps
`default_nettype none

module dwmem_ctrl (
    input wire logic clock,
    input wire logic rstn,
    dwmem_if.ctl dw,
    input wire logic req_valid,
    output logic req_ready,
    input wire dwmem_pkg::dwmem_addr_t req_a,
    input wire dwmem_pkg::dwmem_func_t req_f,
    input wire dwmem_pkg::dwmem_word_t req_w,
    input wire logic init_req,
    input wire logic clear_req,
    output logic rsp_valid,
    output dwmem_pkg::dwmem_word_t rsp_data,
    output logic rsp_q,
    output logic rsp_x,
    output logic rsp_lam
);
    import dwmem_pkg::*;

    typedef struct packed {
        dwmem_state_e state;
        logic ready;
        logic cyc;
        logic n;
        dwmem_addr_t a;
        dwmem_func_t f;
        dwmem_word_t w;
        logic z;
        logic c;
        logic rsp_valid;
        dwmem_word_t rsp_data;
        logic rsp_q;
        logic rsp_x;
        logic rsp_lam;
    } dwmem_ctl_s;

    dwmem_ctl_s s;
    dwmem_ctl_s next_s;

    assign dw.cyc = s.cyc;
    assign dw.n = s.n;
    assign dw.a = s.a;
    assign dw.f = s.f;
    assign dw.w = s.w;
    assign dw.z = s.z;
    assign dw.c = s.c;
    assign req_ready = s.ready;
    assign rsp_valid = s.rsp_valid;
    assign rsp_data = s.rsp_data;
    assign rsp_q = s.rsp_q;
    assign rsp_x = s.rsp_x;
    assign rsp_lam = s.rsp_lam;

    always_comb begin
        next_s = s;
        next_s.rsp_valid = 1'b0;
        next_s.z = init_req;
        next_s.c = clear_req;
        next_s.rsp_lam = dw.lam;
        case (s.state)
            DWMEM_IDLE: begin
                if (req_valid && s.ready) begin
                    next_s.a = req_a;
                    next_s.f = req_f;
                    next_s.w = req_w;
                    next_s.cyc = 1'b1;
                    next_s.n = 1'b1;
                    next_s.ready = 1'b0;
                    next_s.state = DWMEM_CYCLE;
                end
            end
            DWMEM_CYCLE: begin
                next_s.cyc = 1'b0;
                next_s.n = 1'b0;
                next_s.state = DWMEM_ANSWER;
            end
            DWMEM_ANSWER: begin
                // read lines count only while the module drives them
                next_s.rsp_data = dw.r_oe ? dw.r : '0;
                next_s.rsp_q = dw.q;
                next_s.rsp_x = dw.x;
                next_s.rsp_valid = 1'b1;
                next_s.ready = 1'b1;
                next_s.state = DWMEM_IDLE;
            end
            default: begin
                next_s.state = DWMEM_IDLE;
                next_s.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
            s.ready <= 1'b1;
        end else begin
            s <= next_s;
        end
    end
endmodule

`default_nettype wire

// ==== verif/dwmem_monitor.sv ====
// dwmem_monitor: dataway answer checks between controller and memory
// assumes instantiation beside the interface; one clock, rstn active low
`timescale 1ns/1ps
`default_nettype none
`include "dwmem_cfg.svh"
module dwmem_monitor (
    input wire logic clock,
    input wire logic rstn,
    input wire logic cyc,
    input wire logic n,
    input wire dwmem_pkg::dwmem_addr_t a,
    input wire dwmem_pkg::dwmem_func_t f,
    input wire dwmem_pkg::dwmem_word_t r,
    input wire logic r_oe,
    input wire logic q,
    input wire logic x,
    input wire logic ack,
    input wire logic lam
);
    import dwmem_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    wire logic sel = cyc && n;
    property p_answer; sel |=> q && ack; endproperty
    a_answer: assert property (p_answer) else $error("no q answer");
    property p_nolam; !lam; endproperty
    a_nolam: assert property (p_nolam) else $error("lam raised");
    property p_once; ack |=> !ack; endproperty
    a_once: assert property (p_once) else $error("answer too long");
    property p_drive;
        r_oe |-> $past(sel) && $past(f) inside {5'h00, 5'h01, 5'h04};
    endproperty
    a_drive: assert property (p_drive) else $error("read lines driven");
    property p_release; !r_oe |-> r == '0; endproperty
    a_release: assert property (p_release) else $error("read lines held");
    property p_read;
        sel && (f == `DWMEM_F_READ_RAND || f == `DWMEM_F_READ_SEQ && a == 0) |=> r_oe;
    endproperty
    a_read: assert property (p_read) else $error("read not driven");
    property p_wx; sel && f == `DWMEM_F_WRITE_RAND |=> x; endproperty
    a_wx: assert property (p_wx) else $error("write no x");
    property p_refuse; sel && f == `DWMEM_F_WRITE_SEQ && a != 0 |=> !x; endproperty
    a_refuse: assert property (p_refuse) else $error("bad subaddress x");
    property p_addrw;
        sel && f == `DWMEM_F_READ_ADDR && a == 0 |=> r_oe && r[23:4] == '0;
    endproperty
    a_addrw: assert property (p_addrw) else $error("address too wide");
    cover property (sel && f == `DWMEM_F_WRITE_SEQ);
    cover property (r_oe);
    cover property (sel ##1 !x);
endmodule
`default_nettype wire

// ==== verif/dwmem_tb.sv ====
// dwmem_tb: controller and memory joined by the dataway interface
// assumes design files and dwmem_cfg.svh compiled first
`timescale 1ns/1ps
`default_nettype none
`include "dwmem_cfg.svh"
module dwmem_tb;
    import dwmem_pkg::*;
    logic clock = 0;
    logic rstn = 0;
    logic req_valid = 0, req_ready, init_req = 0, clear_req = 0;
    logic rsp_valid, rsp_q, rsp_x, rsp_lam, rear_strobe = 0, rear_ready, panel_clear = 0;
    dwmem_addr_t req_a = 0, display_addr;
    dwmem_func_t req_f = 0;
    dwmem_word_t req_w = 0, rsp_data, rear_data = 0, display;
    int mismatches = 0;
    int tests_run = 0;
    always #50 clock = ~clock;
    dwmem_if dwmem_if_i ();
    dwmem_device dwmem_device_i (.clock(clock), .rstn(rstn), .dw(dwmem_if_i),
        .rear_strobe(rear_strobe), .rear_data(rear_data), .rear_ready(rear_ready),
        .panel_clear(panel_clear), .display(display), .display_addr(display_addr));
    dwmem_ctrl dwmem_ctrl_i (.clock(clock), .rstn(rstn), .dw(dwmem_if_i),
        .req_valid(req_valid), .req_ready(req_ready), .req_a(req_a), .req_f(req_f),
        .req_w(req_w), .init_req(init_req), .clear_req(clear_req), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_q(rsp_q), .rsp_x(rsp_x), .rsp_lam(rsp_lam));
    dwmem_monitor dwmem_monitor_i (.clock(clock), .rstn(rstn), .cyc(dwmem_if_i.cyc),
        .n(dwmem_if_i.n), .a(dwmem_if_i.a), .f(dwmem_if_i.f), .r(dwmem_if_i.r),
        .r_oe(dwmem_if_i.r_oe), .q(dwmem_if_i.q), .x(dwmem_if_i.x), .ack(dwmem_if_i.ack),
        .lam(dwmem_if_i.lam));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one dataway cycle; answer is fixed at two cycles after the take
    task automatic cmd(input dwmem_func_t fv, input dwmem_addr_t av, input dwmem_word_t wv);
        @(posedge clock) #1;
        req_valid = 1;
        req_f = fv;
        req_a = av;
        req_w = wv;
        @(posedge clock);
        #1 req_valid = 0;
        repeat (2) @(posedge clock);
        #1 chk(rsp_valid, 1);
    endtask
    task automatic rd(input dwmem_func_t fv, input dwmem_addr_t av, input dwmem_word_t exp);
        cmd(fv, av, 0);
        chk(rsp_data, exp);
    endtask
    task automatic end_sim;
        if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #(100 * 3000);
        mismatches++;
        end_sim;
    end
    initial begin
        repeat (2) @(posedge clock);
        #1 rstn = 1;
        rd(`DWMEM_F_READ_ADDR, 0, 0);
        rd(`DWMEM_F_READ_RAND, 5, 0);
        for (int i = 0; i < 16; i++) cmd(`DWMEM_F_WRITE_RAND, i[3:0], {20'hc0000, i[3:0]});
        for (int i = 0; i < 16; i++) rd(`DWMEM_F_READ_RAND, i[3:0], {20'hc0000, i[3:0]});
        chk(rsp_x, 1);
        cmd(`DWMEM_F_LOAD_ADDR, 0, 24'h00000e);
        for (int i = 0; i < 3; i++) cmd(`DWMEM_F_WRITE_SEQ, 0, {20'hd0000, i[3:0]});
        rd(`DWMEM_F_READ_ADDR, 0, 1);
        rd(`DWMEM_F_READ_RAND, 15, 24'hd00001);
        rd(`DWMEM_F_READ_RAND, 0, 24'hd00002);
        // upper write bits must be ignored by the load
        cmd(`DWMEM_F_LOAD_ADDR, 0, 24'hfffffe);
        for (int i = 0; i < 3; i++) rd(`DWMEM_F_READ_SEQ, 0, {20'hd0000, i[3:0]});
        rd(`DWMEM_F_READ_ADDR, 0, 1);
        cmd(`DWMEM_F_WRITE_SEQ, 3, 24'h123456);
        chk(rsp_q, 1);
        chk(rsp_x, 0);
        chk(rsp_lam, 0);
        rd(`DWMEM_F_READ_RAND, 3, 24'hc00003);
        rd(`DWMEM_F_READ_ADDR, 0, 1);
        for (int j = 0; j < 2; j++) begin
            cmd(`DWMEM_F_LOAD_ADDR, 0, 24'h000009);
            @(posedge clock) #1;
            init_req = (j == 0);
            clear_req = (j == 1);
            @(posedge clock) #1;
            init_req = 0;
            clear_req = 0;
            rd(`DWMEM_F_READ_ADDR, 0, 0);
        end
        // panel clear also stalls the rear fifo, so it can be filled
        cmd(`DWMEM_F_LOAD_ADDR, 0, 24'h000007);
        @(posedge clock) #1;
        panel_clear = 1;
        rd(`DWMEM_F_READ_ADDR, 0, 0);
        rear_strobe = 1;
        for (int i = 0; i < 34; i++) begin
            rear_data = {16'h0a00, i[7:0]};
            @(posedge clock) #1;
        end
        rear_strobe = 0;
        chk(rear_ready, 0);
        panel_clear = 0;
        repeat (40) @(posedge clock);
        #1 chk(display_addr, 0);
        chk(display, 24'h0a0010);
        for (int i = 0; i < 16; i++) rd(`DWMEM_F_READ_RAND, i[3:0], {20'h0a001, i[3:0]});
        // mid-run reset must clear every word again
        @(posedge clock) #1;
        rstn = 0;
        @(posedge clock) #1;
        rstn = 1;
        chk(display, 0);
        rd(`DWMEM_F_READ_RAND, 4'hf, 0);
        end_sim;
    end
endmodule
`default_nettype wire
